// ==== shared/meter_port_pkg.sv ====
package meter_port_pkg;
    // Bus widths
    localparam int REG_ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 32;
    localparam int PIN_COUNT = 3;

    // Two-wire addressing
    localparam logic [6:0] SLAVE_ADDR = 7'h38;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [2:0] MAX_DATA_BYTES = 3'h4;
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_PTR_HI = 3'h1;
    localparam logic [2:0] IDX_PTR_LO = 3'h2;
    localparam logic [2:0] IDX_DATA = 3'h3;

    // Port selection
    localparam logic [1:0] SS_FALLS_LAST = 2'h2;
    localparam int LOCK_BIT = 1;

    // Locally decoded register addresses
    localparam logic [15:0] PORT_CFG_ADDR = 16'hEC01;
    localparam logic [15:0] FLAG_REG_ADDR = 16'hE502;
    localparam logic [2:0] FLAG_BYTES = 3'h4;

    // Event flags
    localparam int RST_DONE_BIT = 15;

    // Pin idle levels at reset
    localparam logic PIN_IDLE = 1'b1;
endpackage

// ==== core/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Raw pins and filtered levels
    input wire logic [meter_port_pkg::PIN_COUNT-1:0] d,
    output logic [meter_port_pkg::PIN_COUNT-1:0] q
);
    import meter_port_pkg::*;

    logic [PIN_COUNT-1:0] s1_q;
    logic [PIN_COUNT-1:0] s2_q;
    logic [PIN_COUNT-1:0] s3_q;

    // Three stages per pin; level moves only when stages two and three agree
    genvar i;
    for (i = 0; i < PIN_COUNT; i++) begin : g_bit
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                s1_q[i] <= PIN_IDLE;
                s2_q[i] <= PIN_IDLE;
                s3_q[i] <= PIN_IDLE;
                q[i] <= PIN_IDLE;
            end else begin
                s1_q[i] <= d[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i]; // Single-cycle glitches never pass
                end
            end
        end
    end
endmodule

// ==== core/event_flags.sv ====
`timescale 1ns/10ps
module event_flags (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Event sources and enables
    input wire logic [meter_port_pkg::FLAG_W-1:0] events,
    input wire logic [meter_port_pkg::FLAG_W-1:0] irq_enable,
    // Write-back clear
    input wire logic clr_we,
    input wire logic [meter_port_pkg::FLAG_W-1:0] clr_data,
    // Flag state and pin
    output logic [meter_port_pkg::FLAG_W-1:0] flags,
    output logic irq_n
);
    import meter_port_pkg::*;

    logic done_q;
    logic [FLAG_W-1:0] hit;

    // Marks the end of the reset process once
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b1;
        end
    end

    // Sticky flags: a new event beats a write-back in the same cycle
    genvar i;
    for (i = 0; i < FLAG_W; i++) begin : g_flag
        logic set;
        // RQ20 reset finished flag
        assign set = events[i] | ((i == RST_DONE_BIT) & ~done_q);
        // RQ17 write-back clears
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                flags[i] <= 1'b0;
            end else if (set) begin
                flags[i] <= 1'b1;
            end else if (clr_we && clr_data[i]) begin
                flags[i] <= 1'b0;
            end
        end
        // Reset-finished enable is forced on: it cannot be masked
        assign hit[i] = flags[i] & (irq_enable[i] | (i == RST_DONE_BIT));
    end

    // RQ17 pin low on flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|hit;
        end
    end
endmodule

// ==== core/meter_host_port_select_i2c.sv ====
// Overview of operation
// RQ1 - Fast capture port stays off after every reset until enabled.
// RQ2 - Select line held high keeps the two-wire port until hardware reset.
// RQ3 - Three select falling edges choose the four-wire port until reset; the code also returns to two-wire on power-down.
// RQ4 - Host toggles select as plain I/O or via three dummy writes.
// RQ5 - Two-wire lock bit one in port config freezes two-wire choice.
// RQ6 - Any port config write while four-wire locks that choice.
// RQ7 - Lock survives power states; cleared by hardware reset or power-down.
// RQ8 - Two-wire pins share four-wire clock/data; four-wire excludes capture.
// RQ9 - Slave address is 0x38; write address byte is 0x70.
// RQ10 - Write frame: start, address byte, 16-bit pointer, then value.
// RQ11 - Every received byte in writes and read first stage is acked.
// RQ12 - Master sends stop after last value byte acknowledged.
// RQ13 - Pointer and contents travel most significant bit first.
// RQ14 - Read sets pointer, then repeated start with byte 0x71.
// RQ15 - Device sends value bytes; master nacks last, then stops.
// RQ16 - Master keeps the two-wire clock at or below 400 kHz; the test host clocks at 2.5 MHz (400 ns bits).
// RQ17 - Interrupt pin low on flags; writing flags back clears them.
// RQ18 - Host reads linked secondary register before writing flags back.
// RQ19 - Host catches interrupt on falling edge and clears edge first.
// RQ20 - Reset-finished flag is unmaskable and set after each reset.
// RQ21 - Foreign address byte is not acked; data line stays released.
`timescale 1ns/10ps
module meter_host_port_select_i2c (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Shared serial pins
    input wire logic scl_pin,
    input wire logic sda_pin_i,
    output logic sda_pin_o,
    output logic sda_pin_oe_n,
    input wire logic ss_n_pin,
    // Port selection and power
    input wire logic spi_cfg_wr,
    input wire logic power_down,
    input wire logic fast_capture_req,
    output logic four_wire_sel,
    output logic port_locked,
    output logic fast_capture_en,
    // Register access
    output logic [meter_port_pkg::REG_ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic [meter_port_pkg::DATA_W-1:0] reg_wdata,
    output logic [2:0] reg_wbytes,
    output logic reg_rd,
    input wire logic [meter_port_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [2:0] reg_rbytes,
    // Event flags
    input wire logic [meter_port_pkg::FLAG_W-1:0] events,
    input wire logic [meter_port_pkg::FLAG_W-1:0] irq_enable,
    output logic [meter_port_pkg::FLAG_W-1:0] flags,
    output logic interrupt_request_pin_n
);
    import meter_port_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_RX, S_ACK, S_TX, S_ACKIN, S_SKIP
    } i2c_state_t;

    i2c_state_t state_q;
    logic scl_s, sda_s, ss_s;
    logic scl_p_q, sda_p_q, ss_p_q;
    logic scl_rise, scl_fall, ss_fall, start_c, stop_c;
    logic [1:0] ss_cnt_q;
    logic four_wire_q, locked_q, fc_en_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shreg_q, tx_q;
    logic oe_n_q, rw_q, nack_q;
    logic [2:0] rx_idx_q, tx_idx_q, wbytes_q;
    logic [REG_ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic wr_q, rd_q;
    logic byte_done, addr_match, i2c_on;
    logic cfg_wr_i2c, flag_clr;
    logic [DATA_W-1:0] rd_word;
    logic [2:0] rd_len, rem;
    logic [4:0] sh;
    logic [7:0] tx_byte;

    // Pins come from the master's domain
    pin_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({scl_pin, sda_pin_i, ss_n_pin}),
        .q({scl_s, sda_s, ss_s})
    );

    // Previous filtered levels for edge finding
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_p_q <= PIN_IDLE;
            sda_p_q <= PIN_IDLE;
            ss_p_q <= PIN_IDLE;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            ss_p_q <= ss_s;
        end
    end

    // Bus conditions; data moves only while the clock is low
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign ss_fall = ~ss_s & ss_p_q;
    assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // RQ8 pins shared with four-wire
    assign i2c_on = ~four_wire_q;
    assign cfg_wr_i2c = wr_q && (addr_q == PORT_CFG_ADDR);
    assign flag_clr = wr_q && (addr_q == FLAG_REG_ADDR);

    // RQ2 two-wire until three falls
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ss_cnt_q <= 2'h0;
            four_wire_q <= 1'b0;
        end else if (power_down) begin
            ss_cnt_q <= 2'h0;
            four_wire_q <= 1'b0;
        end else if (ss_fall && !locked_q && !four_wire_q) begin
            // RQ3 third fall selects
            if (ss_cnt_q == SS_FALLS_LAST) begin
                four_wire_q <= 1'b1;
            end else begin
                ss_cnt_q <= ss_cnt_q + 2'h1;
            end
        end
    end

    // Lock; only reset or power-down clears it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            locked_q <= 1'b0;
        end else if (power_down) begin
            // RQ7 power-down releases
            locked_q <= 1'b0;
        end else if (i2c_on && cfg_wr_i2c && wdata_q[LOCK_BIT]) begin
            // RQ5 two-wire lock bit
            locked_q <= 1'b1;
        end else if (four_wire_q && spi_cfg_wr) begin
            // RQ6 four-wire any write
            locked_q <= 1'b1;
        end
    end

    // RQ1 capture off after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fc_en_q <= 1'b0;
        end else begin
            // Capture cannot run with the four-wire port
            fc_en_q <= fast_capture_req & i2c_on;
        end
    end

    assign byte_done = (state_q == S_RX) && scl_fall
        && (bit_cnt_q == BITS_PER_BYTE);
    // RQ9 address compare
    assign addr_match = (shreg_q[7:1] == SLAVE_ADDR);

    // Byte to send, top byte first
    always_comb begin
        rd_word = reg_rdata;
        rd_len = reg_rbytes;
        rem = 3'h0;
        sh = 5'h0;
        tx_byte = 8'h00;
        if (addr_q == FLAG_REG_ADDR) begin
            rd_word = flags;
            rd_len = FLAG_BYTES;
        end
        // RQ13 MSB byte first
        if (tx_idx_q < rd_len) begin
            rem = rd_len - tx_idx_q - 3'h1;
            sh = {rem[1:0], 3'h0};
            tx_byte = rd_word[sh +: 8];
        end
    end

    // Two-wire slave sequencing and data line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_q <= 8'h00;
            oe_n_q <= 1'b1;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (!i2c_on || stop_c) begin
            state_q <= S_IDLE;
            oe_n_q <= 1'b1;
        end else if (start_c) begin
            // Repeated start restarts address reception
            state_q <= S_RX;
            bit_cnt_q <= 4'h0;
            oe_n_q <= 1'b1;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    oe_n_q <= 1'b1;
                end
                S_RX: begin
                    if (scl_rise) begin
                        // RQ13 MSB first in
                        shreg_q <= {shreg_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        if (rx_idx_q == IDX_ADDR && !addr_match) begin
                            // RQ21 foreign address
                            state_q <= S_SKIP;
                        end else begin
                            // RQ11 ack each byte
                            state_q <= S_ACK;
                            oe_n_q <= 1'b0;
                            if (rx_idx_q == IDX_ADDR) begin
                                rw_q <= shreg_q[0];
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (rw_q) begin
                            // RQ15 send first byte
                            state_q <= S_TX;
                            tx_q <= {tx_byte[6:0], 1'b0};
                            oe_n_q <= tx_byte[7];
                        end else begin
                            state_q <= S_RX;
                            oe_n_q <= 1'b1;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == LAST_TX_BIT) begin
                            state_q <= S_ACKIN;
                            oe_n_q <= 1'b1;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            oe_n_q <= tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                S_ACKIN: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (nack_q) begin
                            // RQ15 nack ends sending
                            state_q <= S_SKIP;
                        end else begin
                            state_q <= S_TX;
                            tx_q <= {tx_byte[6:0], 1'b0};
                            oe_n_q <= tx_byte[7];
                        end
                    end
                end
                S_SKIP: begin
                    oe_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Frame fields: pointer, write value and send index
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_idx_q <= IDX_ADDR;
            tx_idx_q <= 3'h0;
            wbytes_q <= 3'h0;
            addr_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (start_c) begin
                rx_idx_q <= IDX_ADDR;
                wbytes_q <= 3'h0;
                wdata_q <= 32'h0000_0000;
            end else if (stop_c && state_q != S_SKIP && !rw_q) begin
                // RQ12 stop commits write
                wr_q <= (wbytes_q != 3'h0);
            end else if (byte_done && !(rx_idx_q == IDX_ADDR
                    && !addr_match)) begin
                if (rx_idx_q != IDX_DATA) begin
                    rx_idx_q <= rx_idx_q + 3'h1;
                end
                // RQ10 pointer then value
                if (rx_idx_q == IDX_ADDR) begin
                    tx_idx_q <= 3'h0;
                    rd_q <= shreg_q[0];
                end else if (rx_idx_q == IDX_PTR_HI) begin
                    addr_q[15:8] <= shreg_q;
                end else if (rx_idx_q == IDX_PTR_LO) begin
                    addr_q[7:0] <= shreg_q;
                end else begin
                    // Oldest byte ends up most significant
                    wdata_q <= {wdata_q[23:0], shreg_q};
                    if (wbytes_q != MAX_DATA_BYTES) begin
                        wbytes_q <= wbytes_q + 3'h1;
                    end
                end
            end else if (state_q == S_TX && scl_fall
                    && bit_cnt_q == LAST_TX_BIT) begin
                tx_idx_q <= tx_idx_q + 3'h1; // Ready before next load
            end
        end
    end

    // Flags and interrupt pin
    event_flags u_flags (
        .clk(clk),
        .nrst(nrst),
        .events(events),
        .irq_enable(irq_enable),
        .clr_we(flag_clr),
        .clr_data(wdata_q),
        .flags(flags),
        .irq_n(interrupt_request_pin_n)
    );

    // Open-drain data: only ever pulls low
    assign sda_pin_o = 1'b0;
    assign sda_pin_oe_n = oe_n_q;
    assign four_wire_sel = four_wire_q;
    assign port_locked = locked_q;
    assign fast_capture_en = fc_en_q;
    assign reg_addr = addr_q;
    assign reg_wr = wr_q;
    assign reg_wdata = wdata_q;
    assign reg_wbytes = wbytes_q;
    assign reg_rd = rd_q;
endmodule

// ==== verification/meter_host_port_select_i2c_checker.sv ====
`timescale 1ns/10ps
module meter_host_port_select_i2c_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pin and port choice
    input wire logic sda_pin_oe_n,
    input wire logic power_down,
    input wire logic fast_capture_req,
    input wire logic four_wire_sel,
    input wire logic port_locked,
    input wire logic fast_capture_en,
    // Register access and flags
    input wire logic [meter_port_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [meter_port_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [2:0] reg_wbytes,
    input wire logic reg_rd,
    input wire logic [meter_port_pkg::FLAG_W-1:0] irq_enable,
    input wire logic [meter_port_pkg::FLAG_W-1:0] flags,
    input wire logic interrupt_request_pin_n
);
    import meter_port_pkg::*;
    logic [1:0] boot_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Edges since reset release, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_q <= 2'h0;
        end else if (boot_q != 2'h3) begin
            boot_q <= boot_q + 2'h1;
        end
    end

    cap_gate_a: assert property (
        fast_capture_en |-> $past(fast_capture_req && !four_wire_sel))
        else $error("capture port on without a two-wire request");
    lock_hold_a: assert property (
        port_locked && !power_down |=> port_locked)
        else $error("port lock dropped without power-down");
    sel_frozen_a: assert property (
        port_locked && !power_down |=> $stable(four_wire_sel))
        else $error("locked port choice changed");
    sel_sticky_a: assert property (
        four_wire_sel && !power_down |=> four_wire_sel)
        else $error("four-wire choice lost before reset");
    irq_level_a: assert property (
        interrupt_request_pin_n ==
        !(|($past(flags) & ($past(irq_enable) | 32'h0000_8000))))
        else $error("interrupt pin level disagrees with flags");
    boot_flag_a: assert property (
        boot_q == 2'h1 |-> flags[RST_DONE_BIT] ##1 !interrupt_request_pin_n)
        else $error("reset-finished flag or pin missing after reset");
    flag_clear_a: assert property (
        $fell(flags[RST_DONE_BIT]) |->
        $past(reg_wr && reg_addr == FLAG_REG_ADDR && reg_wdata[RST_DONE_BIT]))
        else $error("reset-finished flag cleared without write-back");
    link_quiet_a: assert property (
        $past(four_wire_sel) && four_wire_sel |-> sda_pin_oe_n)
        else $error("data pin driven while four-wire chosen");
    wr_pulse_a: assert property (
        reg_wr |-> reg_wbytes != 3'h0 && reg_wbytes <= MAX_DATA_BYTES
        ##1 !reg_wr)
        else $error("bad register write pulse");
    rd_pulse_a: assert property (
        reg_rd |=> !reg_rd)
        else $error("read request longer than one cycle");
endmodule

bind meter_host_port_select_i2c meter_host_port_select_i2c_checker u_chk (
    .clk(clk), .nrst(nrst), .sda_pin_oe_n(sda_pin_oe_n),
    .power_down(power_down), .fast_capture_req(fast_capture_req),
    .four_wire_sel(four_wire_sel), .port_locked(port_locked),
    .fast_capture_en(fast_capture_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_wbytes(reg_wbytes),
    .reg_rd(reg_rd), .irq_enable(irq_enable), .flags(flags),
    .interrupt_request_pin_n(interrupt_request_pin_n)
);

// ==== verification/i2c_host_model.sv ====
`timescale 1ns/10ps
module i2c_host_model (
    // Open-drain bus lines
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    // Both lines idle released
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // sped up to 400 ns; long low phase covers sync lag
    task automatic bit_io(input logic b, output logic r);
        #150 sda_rel = b;
        #150 scl = 1'b1;
        #99 r = sda;
        #1 scl = 1'b0;
    endtask

    // Start, or repeated start when the clock is low
    task automatic start();
        #150 sda_rel = 1'b1;
        #150 scl = 1'b1;
        #200 sda_rel = 1'b0;
        #200 scl = 1'b0;
    endtask

    task automatic stop();
        #150 sda_rel = 1'b0;
        #150 scl = 1'b1;
        #200 sda_rel = 1'b1;
        #400;
    endtask

    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(last, r);
    endtask
endmodule

// ==== verification/meter_host_port_select_i2c_tb_top.sv ====
`timescale 1ns/10ps
module meter_host_port_select_i2c_tb_top;
    import meter_port_pkg::*;
    logic clk, nrst, scl_pin, sda_rel, sda_wire, sda_pin_o, sda_pin_oe_n;
    logic ss_n_pin, spi_cfg_wr, power_down, fast_capture_req, ack;
    logic four_wire_sel, port_locked, fast_capture_en, reg_wr, reg_rd;
    logic interrupt_request_pin_n;
    logic [2:0] reg_wbytes, reg_rbytes, wr_bytes;
    logic [15:0] reg_addr, wr_addr;
    logic [31:0] reg_wdata, reg_rdata, wr_data, events, irq_enable, flags;
    logic [31:0] rng_state = 32'h0000_0055;
    int failures = 0;
    int checked = 0;
    int reads = 0;

    // Pull-up: low when either side pulls
    assign sda_wire = sda_rel & (sda_pin_oe_n | sda_pin_o);

    meter_host_port_select_i2c u_dut (
        .clk(clk), .nrst(nrst), .scl_pin(scl_pin), .sda_pin_i(sda_wire),
        .sda_pin_o(sda_pin_o), .sda_pin_oe_n(sda_pin_oe_n),
        .ss_n_pin(ss_n_pin), .spi_cfg_wr(spi_cfg_wr),
        .power_down(power_down), .fast_capture_req(fast_capture_req),
        .four_wire_sel(four_wire_sel), .port_locked(port_locked),
        .fast_capture_en(fast_capture_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_wbytes(reg_wbytes),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rbytes(reg_rbytes),
        .events(events), .irq_enable(irq_enable), .flags(flags),
        .interrupt_request_pin_n(interrupt_request_pin_n)
    );
    i2c_host_model u_host (.scl(scl_pin), .sda_rel(sda_rel), .sda(sda_wire));

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Last committed write and read pulses
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            wr_addr <= reg_addr;
            wr_data <= reg_wdata;
            wr_bytes <= reg_wbytes;
        end
        if (reg_rd === 1'b1) begin
            reads <= reads + 1;
        end
    end

    function automatic logic [31:0] xs();
        rng_state ^= rng_state << 13;
        rng_state ^= rng_state >> 17;
        rng_state ^= rng_state << 5;
        return rng_state;
    endfunction

    // Only the last n bytes survive
    function automatic logic [31:0] keep(input logic [31:0] v, input int n);
        return (n == 4) ? v : v & ((32'h1 << (8 * n)) - 32'h1);
    endfunction

    function automatic logic pin_exp(input logic [31:0] f, e);
        return ~|(f & (e | 32'h0000_8000));
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Read outputs past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(4);
    endtask

    task automatic toggle_ss();
        for (int i = 0; i < 3; i++) begin
            tick(6);
            ss_n_pin = 1'b0;
            tick(6);
            ss_n_pin = 1'b1;
        end
        tick(6);
    endtask

    task automatic wr_frame(input logic [15:0] a, input logic [31:0] v,
                            input int n);
        u_host.start();
        u_host.put_byte(8'h70, ack);
        chk("addr ack", 1, ack);
        u_host.put_byte(a[15:8], ack);
        chk("ptr ack", 1, ack);
        u_host.put_byte(a[7:0], ack);
        chk("ptr ack", 1, ack);
        for (int k = n - 1; k >= 0; k--) begin
            u_host.put_byte(v[8*k +: 8], ack);
            chk("data ack", 1, ack);
        end
        u_host.stop();
        chk("wr addr", a, wr_addr);
        chk("wr data", keep(v, n), wr_data);
        chk("wr bytes", n, wr_bytes);
    endtask

    task automatic rd_frame(input logic [15:0] a, input int n,
                            output logic [31:0] v);
        logic [7:0] b;
        u_host.start();
        u_host.put_byte(8'h70, ack);
        u_host.put_byte(a[15:8], ack);
        u_host.put_byte(a[7:0], ack);
        u_host.start();
        u_host.put_byte(8'h71, ack);
        chk("rd addr ack", 1, ack);
        v = 32'h0;
        for (int k = 0; k < n; k++) begin
            u_host.get_byte(k == n - 1, b);
            v = {v[23:0], b};
        end
        u_host.stop();
    endtask

    // Main sequence
    initial begin
        logic [31:0] v, f;
        logic [15:0] a;
        int n;
        {nrst, spi_cfg_wr, power_down, fast_capture_req} = 4'h0;
        ss_n_pin = 1'b1;
        reg_rdata = 32'h0;
        reg_rbytes = 3'h4;
        events = 32'h0;
        irq_enable = 32'h0;
        tick(4);
        nrst = 1'b1;
        tick(6);
        chk("reset flag", 1, flags[RST_DONE_BIT]);
        chk("irq pin", 0, interrupt_request_pin_n);
        chk("capture en", 0, fast_capture_en);
        wr_frame(FLAG_REG_ADDR, 32'h0000_8000, 4);
        chk("irq pin", 1, interrupt_request_pin_n);
        for (int i = 0; i < 6; i++) begin
            n = (i % 3 == 2) ? 4 : i % 3 + 1;
            v = xs();
            a = {4'h4, v[11:0]};
            wr_frame(a, xs(), n);
            tick(1);
            reg_rdata = xs();
            reg_rbytes = 3'(n);
            rd_frame(a, n, f);
            chk("rd ptr", a, reg_addr);
            chk("rd data", keep(reg_rdata, n), f);
        end
        chk("four wire", 0, four_wire_sel);
        u_host.start();
        u_host.put_byte(8'h72, ack);
        chk("foreign ack", 0, ack);
        u_host.put_byte(8'h00, ack);
        chk("foreign data", 0, ack);
        u_host.stop();
        for (int i = 0; i < 4; i++) begin
            v = xs();
            tick(1);
            irq_enable = i[0] ? v : ~v;
            events = 32'h1 << v[4:0];
            tick(1);
            events = 32'h0;
            tick(3);
            f = 32'h1 << v[4:0];
            chk("flags", f, flags);
            chk("irq pin", pin_exp(f, irq_enable),
                interrupt_request_pin_n);
            rd_frame(FLAG_REG_ADDR, 4, v);
            chk("flag read", f, v);
            wr_frame(FLAG_REG_ADDR, f, 4);
            chk("flags clr", 0, flags);
            chk("irq clr", 1, interrupt_request_pin_n);
        end
        fast_capture_req = 1'b1;
        tick(3);
        chk("capture en", 1, fast_capture_en);
        wr_frame(PORT_CFG_ADDR, 32'h02, 1);
        chk("locked", 1, port_locked);
        toggle_ss();
        chk("four wire", 0, four_wire_sel);
        pulse(power_down);
        chk("locked", 0, port_locked);
        toggle_ss();
        chk("four wire", 1, four_wire_sel);
        chk("capture en", 0, fast_capture_en);
        pulse(spi_cfg_wr);
        chk("locked", 1, port_locked);
        u_host.start();
        u_host.put_byte(8'h70, ack);
        chk("ignored ack", 0, ack);
        u_host.stop();
        tick(1);
        {nrst, fast_capture_req} = 2'h0;
        tick(4);
        nrst = 1'b1;
        tick(6);
        chk("four wire", 0, four_wire_sel);
        chk("locked", 0, port_locked);
        chk("capture en", 0, fast_capture_en);
        chk("reset flag", 1, flags[RST_DONE_BIT]);
        chk("rd pulses", 10, reads);
        finish_test();
    end

    // Watchdog far above run length
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
endmodule
